// ### rtl/bstap_port.sv
// boundary-scan test access port with boundary chain and config access
// Contract
// - mandatory instructions extest, sample, bypass supported
// - five-bit opcode; 00000 extest, 00001 sample, 11111 bypass
// - 00010/00011 select user scan registers one, two
// - 00100 config readback, 00101 config load
// - 00111 puts boundary register in internal test
// - 01000 shifts out configured user code
// - 01001 shifts out identification code
// - public instructions work before and after configuration
// - user interface shows reset, update, shift states
// - pin block bits ordered input, output, enable
// - input-only one bit, output-only three bits
// - every pin block in one tri-state chain
// - test capability stays after configuration
// - extest captures internal signals at pin cells
// - chain starts at corner pin, fixed order
`timescale 1ns/1ps
module bstap_port #(
	parameter int           NUM_PINS  = 4,
	parameter logic [7:0]   PIN_KIND  = 8'h24,
	// arbitrary neutral identification value
	parameter logic [31:0]  ID_VALUE  = 32'h0000_0001
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  srst,
	// serial test link
	input  wire logic                  tck,
	input  wire logic                  tms,
	input  wire logic                  tdi,
	output logic                       tdo,
	output logic                       tdo_oe,
	// pins and core
	input  wire logic [NUM_PINS-1:0]   pad_in,
	output logic      [NUM_PINS-1:0]   pad_out,
	output logic      [NUM_PINS-1:0]   pad_oe,
	input  wire logic [NUM_PINS-1:0]   core_out,
	input  wire logic [NUM_PINS-1:0]   core_oe,
	output logic      [NUM_PINS-1:0]   core_in,
	// configuration state
	input  wire logic                  configured,
	input  wire logic [31:0]           user_code,
	// user scan registers
	output bstap_pkg::bstap_user_t     user_ctl,
	input  wire logic                  user_one_tdo,
	input  wire logic                  user_two_tdo,
	// configuration load words
	output logic [31:0]                cfg_wr_data,
	output logic                       cfg_wr_valid,
	input  wire logic                  cfg_wr_ready,
	output logic                       cfg_wr_stall,
	// configuration readback words
	input  wire logic [31:0]           cfg_rd_data,
	input  wire logic                  cfg_rd_valid,
	output logic                       cfg_rd_ready
);

	// ************************************************************
	// chain layout
	// ************************************************************
	function automatic int pin_cells(input int p);
		if (PIN_KIND[2*p +: 2] == bstap_pkg::PIN_IN_ONLY)
			return bstap_pkg::CELLS_INPUT;
		return bstap_pkg::CELLS_FULL;
	endfunction

	function automatic int pin_base(input int p);
		int s;
		s = 0;
		for (int i = 0; i < p; i++)
			s += pin_cells(i);
		return s;
	endfunction

	localparam int BSR_LEN = pin_base(NUM_PINS);
	localparam int CNT_W   = $clog2(bstap_pkg::WORD_W);

	// ************************************************************
	// link synchronisers and tck edges
	// ************************************************************
	logic                tck_s1, tck_s2, tck_s3, tms_s1, tms_s2;
	logic                tdi_s1, tdi_s2;
	logic [NUM_PINS-1:0] pad_s1, pad_s2;
	logic                rise, fall;

	// two flops on tms, tdi and pad_in, three on tck; core and configuration inputs unsynchronised
	always_ff @(posedge ref_clk) begin
		tck_s1 <= tck;
		tck_s2 <= tck_s1;
		tck_s3 <= tck_s2;
		tms_s1 <= tms;
		tms_s2 <= tms_s1;
		tdi_s1 <= tdi;
		tdi_s2 <= tdi_s1;
		pad_s1 <= pad_in;
		pad_s2 <= pad_s1;
	end

	assign rise = tck_s2 & ~tck_s3;
	assign fall = ~tck_s2 & tck_s3;

	// ************************************************************
	// controller
	// ************************************************************
	bstap_pkg::bstap_state_t state_reg, state_next;

	// standard test logic state walk
	always_comb begin
		unique case (state_reg)
			bstap_pkg::ST_RESET:    state_next = tms_s2 ? bstap_pkg::ST_RESET    : bstap_pkg::ST_IDLE;
			bstap_pkg::ST_IDLE:     state_next = tms_s2 ? bstap_pkg::ST_SEL_DR   : bstap_pkg::ST_IDLE;
			bstap_pkg::ST_SEL_DR:   state_next = tms_s2 ? bstap_pkg::ST_SEL_IR   : bstap_pkg::ST_CAP_DR;
			bstap_pkg::ST_CAP_DR:   state_next = tms_s2 ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
			bstap_pkg::ST_SHIFT_DR: state_next = tms_s2 ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
			bstap_pkg::ST_EXIT1_DR: state_next = tms_s2 ? bstap_pkg::ST_UPD_DR   : bstap_pkg::ST_PAUSE_DR;
			bstap_pkg::ST_PAUSE_DR: state_next = tms_s2 ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
			bstap_pkg::ST_EXIT2_DR: state_next = tms_s2 ? bstap_pkg::ST_UPD_DR   : bstap_pkg::ST_SHIFT_DR;
			bstap_pkg::ST_UPD_DR:   state_next = tms_s2 ? bstap_pkg::ST_SEL_DR   : bstap_pkg::ST_IDLE;
			bstap_pkg::ST_SEL_IR:   state_next = tms_s2 ? bstap_pkg::ST_RESET    : bstap_pkg::ST_CAP_IR;
			bstap_pkg::ST_CAP_IR:   state_next = tms_s2 ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
			bstap_pkg::ST_SHIFT_IR: state_next = tms_s2 ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
			bstap_pkg::ST_EXIT1_IR: state_next = tms_s2 ? bstap_pkg::ST_UPD_IR   : bstap_pkg::ST_PAUSE_IR;
			bstap_pkg::ST_PAUSE_IR: state_next = tms_s2 ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
			bstap_pkg::ST_EXIT2_IR: state_next = tms_s2 ? bstap_pkg::ST_UPD_IR   : bstap_pkg::ST_SHIFT_IR;
			bstap_pkg::ST_UPD_IR:   state_next = tms_s2 ? bstap_pkg::ST_SEL_DR   : bstap_pkg::ST_IDLE;
		endcase
	end

	// state moves on sampled rising tck
	always_ff @(posedge ref_clk) begin
		if (srst)
			state_reg <= bstap_pkg::ST_RESET;
		else if (rise)
			state_reg <= state_next;
	end

	// ************************************************************
	// instruction register
	// ************************************************************
	logic [4:0] ir_shift_reg, ir_reg;

	// capture, shift on rise; update on fall
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ir_shift_reg <= bstap_pkg::IR_CAPTURE;
			ir_reg       <= bstap_pkg::OP_IDCODE;
		end else begin
			if (rise && state_reg == bstap_pkg::ST_CAP_IR)
				ir_shift_reg <= bstap_pkg::IR_CAPTURE;
			else if (rise && state_reg == bstap_pkg::ST_SHIFT_IR)
				ir_shift_reg <= {tdi_s2, ir_shift_reg[4:1]};
			if (fall && state_reg == bstap_pkg::ST_RESET)
				ir_reg <= bstap_pkg::OP_IDCODE;
			else if (fall && state_reg == bstap_pkg::ST_UPD_IR)
				ir_reg <= ir_shift_reg;
		end
	end

	// instruction decodes, reserved codes act as bypass
	logic sel_extest, sel_intest, sel_bsr, sel_u1, sel_u2;
	logic sel_rd, sel_ld, sel_uc, sel_id, sel_hiz, sel_start;
	assign sel_extest = (ir_reg == bstap_pkg::OP_EXTEST);
	assign sel_intest = (ir_reg == bstap_pkg::OP_INTEST);
	assign sel_bsr    = sel_extest | sel_intest
			| (ir_reg == bstap_pkg::OP_SAMPLE);
	assign sel_u1     = (ir_reg == bstap_pkg::OP_USER_ONE);
	assign sel_u2     = (ir_reg == bstap_pkg::OP_USER_TWO);
	assign sel_rd     = (ir_reg == bstap_pkg::OP_CFG_READ);
	assign sel_ld     = (ir_reg == bstap_pkg::OP_CFG_LOAD);
	assign sel_uc     = (ir_reg == bstap_pkg::OP_USER_CODE);
	assign sel_id     = (ir_reg == bstap_pkg::OP_IDCODE);
	assign sel_hiz    = (ir_reg == bstap_pkg::OP_HIZ);
	assign sel_start  = (ir_reg == bstap_pkg::OP_START);

	logic cap_dr, shf_dr, upd_dr;
	assign cap_dr = rise && state_reg == bstap_pkg::ST_CAP_DR;
	assign shf_dr = rise && state_reg == bstap_pkg::ST_SHIFT_DR;
	assign upd_dr = fall && state_reg == bstap_pkg::ST_UPD_DR;

	// ************************************************************
	// boundary register
	// ************************************************************
	logic [BSR_LEN-1:0] bsr_reg, bsr_upd_reg, bsr_cap;

	// per pin cells, pin 0 nearest tdo
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		localparam int B = pin_base(p);
		if (pin_cells(p) == bstap_pkg::CELLS_INPUT) begin : g_in
			assign bsr_cap[B] = pad_s2[p];
			assign pad_out[p] = 1'b0;
			assign pad_oe[p]  = 1'b0;
		end else begin : g_full
			// in, out, enable order
			assign bsr_cap[B + bstap_pkg::CELL_IN]  = pad_s2[p];
			assign bsr_cap[B + bstap_pkg::CELL_OUT] = core_out[p];
			assign bsr_cap[B + bstap_pkg::CELL_OE]  = core_oe[p];
			// test drive holds after configuration too
			assign pad_out[p] = (sel_extest | sel_intest)
					? bsr_upd_reg[B + bstap_pkg::CELL_OUT] : core_out[p];
			assign pad_oe[p]  = sel_hiz ? 1'b0 : (sel_extest | sel_intest)
					? bsr_upd_reg[B + bstap_pkg::CELL_OE] : core_oe[p];
		end
		assign core_in[p] = sel_intest
				? bsr_upd_reg[B + bstap_pkg::CELL_IN] : pad_s2[p];
	end

	// one chain through all pin blocks
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bsr_reg     <= '0;
			bsr_upd_reg <= '0;
		end else begin
			if (cap_dr && sel_bsr)
				bsr_reg <= bsr_cap;
			else if (shf_dr && sel_bsr)
				bsr_reg <= {tdi_s2, bsr_reg[BSR_LEN-1:1]};
			if (upd_dr && sel_bsr)
				bsr_upd_reg <= bsr_reg;
		end
	end

	// ************************************************************
	// bypass, code and readback registers
	// ************************************************************
	logic        byp_reg;
	logic [31:0] word_reg;
	logic        word_sel;
	assign word_sel = sel_uc | sel_id | sel_rd;

	// bypass bit and word-wide shift register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			byp_reg  <= bstap_pkg::BYPASS_CAPTURE;
			word_reg <= '0;
		end else begin
			if (cap_dr)
				byp_reg <= bstap_pkg::BYPASS_CAPTURE;
			else if (shf_dr)
				byp_reg <= tdi_s2;
			if (cap_dr && sel_id)
				word_reg <= ID_VALUE;
			else if (cap_dr && sel_uc)
				word_reg <= configured ? user_code
						: bstap_pkg::USER_CODE_NONE;
			else if (cap_dr && sel_rd)
				word_reg <= cfg_rd_data;
			else if (shf_dr && word_sel)
				word_reg <= {tdi_s2, word_reg[31:1]};
		end
	end

	// readback word taken at capture
	assign cfg_rd_ready = cap_dr & sel_rd & cfg_rd_valid;

	// ************************************************************
	// configuration load path with two-entry buffer
	// ************************************************************
	logic [31:0]      asm_reg;
	logic [CNT_W-1:0] bit_cnt_reg;
	logic             push;
	logic [31:0]      buf_mem [2];
	logic [1:0]       buf_cnt_reg;
	logic             buf_wr_ptr_reg, buf_rd_ptr_reg;
	logic             buf_full, pop;

	assign buf_full     = (buf_cnt_reg == 2'h2);
	assign cfg_wr_stall = buf_full;
	assign push = shf_dr && sel_ld && !buf_full
			&& bit_cnt_reg == CNT_W'(bstap_pkg::WORD_W - 1);

	// assemble words, bits dropped while buffer full
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			asm_reg     <= '0;
			bit_cnt_reg <= '0;
		end else if (cap_dr && sel_ld) begin
			bit_cnt_reg <= '0;
		end else if (shf_dr && sel_ld && !buf_full) begin
			asm_reg     <= {tdi_s2, asm_reg[31:1]};
			bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
		end
	end

	assign pop          = cfg_wr_valid & cfg_wr_ready;
	assign cfg_wr_valid = (buf_cnt_reg != 2'h0);
	assign cfg_wr_data  = buf_mem[buf_rd_ptr_reg];

	// two-entry word buffer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			buf_cnt_reg    <= 2'h0;
			buf_wr_ptr_reg <= 1'b0;
			buf_rd_ptr_reg <= 1'b0;
		end else begin
			if (push) begin
				buf_mem[buf_wr_ptr_reg] <= {tdi_s2, asm_reg[31:1]};
				buf_wr_ptr_reg          <= ~buf_wr_ptr_reg;
			end
			if (pop)
				buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// ************************************************************
	// user scan interface
	// ************************************************************
	always_comb begin
		user_ctl         = '0;
		user_ctl.sel_one = sel_u1;
		user_ctl.sel_two = sel_u2;
		user_ctl.reset   = (state_reg == bstap_pkg::ST_RESET);
		user_ctl.capture = (state_reg == bstap_pkg::ST_CAP_DR);
		user_ctl.shift   = (state_reg == bstap_pkg::ST_SHIFT_DR);
		user_ctl.update  = (state_reg == bstap_pkg::ST_UPD_DR);
		user_ctl.step    = rise & (sel_u1 | sel_u2 | (sel_start
				& state_reg == bstap_pkg::ST_IDLE));
		user_ctl.tdi     = tdi_s2;
	end

	// ************************************************************
	// serial output
	// ************************************************************
	logic dr_out;
	always_comb begin
		if (sel_bsr)
			dr_out = bsr_reg[0];
		else if (sel_u1)
			dr_out = user_one_tdo;
		else if (sel_u2)
			dr_out = user_two_tdo;
		else if (word_sel)
			dr_out = word_reg[0];
		else
			dr_out = byp_reg;
	end

	// tdo changes on falling tck only
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (fall) begin
			tdo    <= (state_reg == bstap_pkg::ST_SHIFT_IR)
					? ir_shift_reg[0] : dr_out;
			tdo_oe <= (state_reg == bstap_pkg::ST_SHIFT_IR)
					| (state_reg == bstap_pkg::ST_SHIFT_DR);
		end
	end

endmodule

// ### include/bstap_pkg.sv
// package for the boundary-scan test access port
package bstap_pkg;

	// ************************************************************
	// instruction register
	// ************************************************************
	localparam int         IR_W         = 5;
	localparam logic [4:0] OP_EXTEST    = 5'h00;
	localparam logic [4:0] OP_SAMPLE    = 5'h01;
	localparam logic [4:0] OP_USER_ONE  = 5'h02;
	localparam logic [4:0] OP_USER_TWO  = 5'h03;
	localparam logic [4:0] OP_CFG_READ  = 5'h04;
	localparam logic [4:0] OP_CFG_LOAD  = 5'h05;
	localparam logic [4:0] OP_INTEST    = 5'h07;
	localparam logic [4:0] OP_USER_CODE = 5'h08;
	localparam logic [4:0] OP_IDCODE    = 5'h09;
	localparam logic [4:0] OP_HIZ       = 5'h0A;
	localparam logic [4:0] OP_START     = 5'h0C;
	localparam logic [4:0] OP_BYPASS    = 5'h1F;
	// fixed capture pattern of the instruction register
	localparam logic [4:0] IR_CAPTURE   = 5'h01;

	// ************************************************************
	// data registers
	// ************************************************************
	localparam int          WORD_W         = 32;
	localparam logic [31:0] USER_CODE_NONE = 32'hFFFF_FFFF;
	localparam logic        BYPASS_CAPTURE = 1'b0;
	// pin block kinds, two bits per pin
	localparam logic [1:0]  PIN_BIDIR    = 2'h0;
	localparam logic [1:0]  PIN_IN_ONLY  = 2'h1;
	localparam logic [1:0]  PIN_OUT_ONLY = 2'h2;
	localparam int          CELLS_FULL   = 3;
	localparam int          CELLS_INPUT  = 1;
	localparam int          CELL_IN      = 0;
	localparam int          CELL_OUT     = 1;
	localparam int          CELL_OE      = 2;

	// ************************************************************
	// controller states
	// ************************************************************
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} bstap_state_t;

	// user scan register side
	typedef struct packed {
		logic sel_one;
		logic sel_two;
		logic reset;
		logic capture;
		logic shift;
		logic update;
		logic step;
		logic tdi;
	} bstap_user_t;

endpackage

// ### sim/bstap_port_monitor.sv
// assertion checker for the boundary-scan test port
`timescale 1ns/1ps
module bstap_port_monitor (
	// clock and reset
	input wire logic                   ref_clk,
	input wire logic                   srst,
	// serial link
	input wire logic                   tck,
	input wire logic                   tdo,
	input wire logic                   tdo_oe,
	// user and configuration sides
	input wire bstap_pkg::bstap_user_t user_ctl,
	input wire logic [31:0]            cfg_wr_data,
	input wire logic                   cfg_wr_valid,
	input wire logic                   cfg_wr_ready,
	input wire logic                   cfg_wr_stall,
	input wire logic                   cfg_rd_valid,
	input wire logic                   cfg_rd_ready
);
	logic t1_reg;
	logic t2_reg;
	logic t3_reg;
	logic rise;
	logic fall;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// own copy of the test clock synchroniser
	always_ff @(posedge ref_clk) begin
		t1_reg <= tck;
		t2_reg <= t1_reg;
		t3_reg <= t2_reg;
	end
	// detected test clock edges
	assign rise = t2_reg & ~t3_reg;
	assign fall = ~t2_reg & t3_reg;
	tdo_on_fall_a: assert property ($changed(tdo) |-> $past(fall) || $past(fall, 2))
		else $error("serial output moved off a clock fall");
	oe_on_fall_a: assert property ($changed(tdo_oe) |-> $past(fall) || $past(fall, 2))
		else $error("output enable moved off a clock fall");
	reset_entry_a: assert property ($fell(srst) |-> user_ctl.reset && !tdo_oe)
		else $error("controller not in reset state after reset");
	user_select_a: assert property (!(user_ctl.sel_one && user_ctl.sel_two))
		else $error("both user registers selected");
	user_states_a: assert property ($onehot0({user_ctl.reset, user_ctl.shift, user_ctl.update, user_ctl.capture}))
		else $error("user state outputs overlap");
	step_pulse_a: assert property (user_ctl.step |=> !user_ctl.step)
		else $error("user step longer than one cycle");
	step_rise_a: assert property (user_ctl.step |-> rise || $past(rise) || $past(rise, 2))
		else $error("user step without a clock rise");
	wr_hold_a: assert property (cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid && $stable(cfg_wr_data))
		else $error("load word dropped while stalled");
	stall_full_a: assert property (cfg_wr_stall |-> cfg_wr_valid)
		else $error("stall raised with empty buffer");
	rd_ready_a: assert property (cfg_rd_ready |-> cfg_rd_valid ##1 !cfg_rd_ready)
		else $error("readback ready not a single pulse on valid");
	cover property (cfg_wr_stall);
	cover property (cfg_rd_ready);
	cover property (user_ctl.step && user_ctl.sel_one);
endmodule
bind bstap_port bstap_port_monitor bstap_port_monitor_inst (
	.ref_clk(ref_clk), .srst(srst), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
	.user_ctl(user_ctl), .cfg_wr_data(cfg_wr_data),
	.cfg_wr_valid(cfg_wr_valid), .cfg_wr_ready(cfg_wr_ready),
	.cfg_wr_stall(cfg_wr_stall), .cfg_rd_valid(cfg_rd_valid),
	.cfg_rd_ready(cfg_rd_ready)
);

// ### sim/bstap_tester.sv
// behavioural test-link master driving the serial port
`timescale 1ns/1ps
module bstap_tester (
	// clock
	input wire logic ref_clk,
	// serial link
	output logic     tck,
	output logic     tms,
	output logic     tdi,
	input wire logic tdo
);
	// clock parked high, mode select at reset level
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// one bit: change on the fall, read output while high
	task automatic clk_bit(input logic m, input logic d, output logic q);
		@(posedge ref_clk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge ref_clk);
		tck <= 1'b1;
		repeat (2) @(posedge ref_clk);
		q = tdo;
		@(posedge ref_clk);
		#1;
	endtask
	// five mode-select highs then idle
	task automatic to_idle;
		logic q;
		repeat (5) clk_bit(1'b1, ~tdi, q);
		clk_bit(1'b0, ~tdi, q);
	endtask
	// idle to shift, n bits lsb first, back to idle
	task automatic scan(input logic is_ir, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = 32'h0;
		clk_bit(1'b1, ~tdi, q);
		if (is_ir)
			clk_bit(1'b1, ~tdi, q);
		clk_bit(1'b0, ~tdi, q);
		clk_bit(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			clk_bit(i == n - 1, din[i], q);
			dout[i] = q;
		end
		clk_bit(1'b1, ~tdi, q);
		clk_bit(1'b0, ~tdi, q);
	endtask
endmodule

// ### sim/tb_bstap_port.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb_bstap_port;
	localparam int          NP    = 4;
	localparam logic [7:0]  KIND  = 8'h24;
	// arbitrary identification value
	localparam logic [31:0] ID    = 32'h0000_0001;
	localparam int          BL    = 10;
	localparam int          LIMIT = 20000;
	logic                   ref_clk = 1'b0;
	logic                   srst = 1'b1;
	logic                   tck, tms, tdi, tdo, tdo_oe;
	logic [NP-1:0]          pad_in = 4'h0, core_out = 4'h0, core_oe = 4'h0;
	logic [NP-1:0]          pad_out, pad_oe, core_in;
	logic                   configured = 1'b0, one_tdo = 1'b0, two_tdo = 1'b0;
	logic [31:0]            user_code = 32'h0, rd_data = 32'h0;
	logic [31:0]            wr_data, got;
	logic                   wr_valid, wr_stall, rd_ready;
	logic                   wr_ready = 1'b0, rd_valid = 1'b0;
	bstap_pkg::bstap_user_t user_ctl;
	int                     fail_count = 0, tests_run = 0, cycles = 0;
	int                     rd_pulses = 0, step_count = 0;
	always #12.5 ref_clk = ~ref_clk;
	bstap_port #(.NUM_PINS(NP), .PIN_KIND(KIND), .ID_VALUE(ID))
	bstap_port_inst (
		.ref_clk(ref_clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe),
		.core_in(core_in), .configured(configured), .user_code(user_code),
		.user_ctl(user_ctl), .user_one_tdo(one_tdo), .user_two_tdo(two_tdo),
		.cfg_wr_data(wr_data), .cfg_wr_valid(wr_valid),
		.cfg_wr_ready(wr_ready), .cfg_wr_stall(wr_stall),
		.cfg_rd_data(rd_data), .cfg_rd_valid(rd_valid), .cfg_rd_ready(rd_ready)
	);
	bstap_tester bstap_tester_inst (
		.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo)
	);
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chk_flag(input string what, input logic exp, input logic seen);
		chk_word(what, {31'h0, exp}, {31'h0, seen});
	endtask
	// expected chain image: per pin in, out, enable; input-only pins in only
	function automatic logic [31:0] cells(input logic [3:0] a, b, c);
		int k;
		cells = 32'h0;
		k = 0;
		for (int p = 0; p < NP; p++) begin
			cells[k] = a[p];
			k++;
			if (KIND[2*p +: 2] != bstap_pkg::PIN_IN_ONLY) begin
				cells[k] = b[p];
				cells[k+1] = c[p];
				k += 2;
			end
		end
	endfunction
	// count readback takes and user step pulses
	always @(posedge ref_clk) begin
		if (rd_ready)
			rd_pulses++;
		if (user_ctl.step)
			step_count++;
	end
	task automatic ir(input logic [4:0] op);
		logic [31:0] cap;
		bstap_tester_inst.scan(1'b1, 5, {27'h0, op}, cap);
		chk_word("ir capture", {27'h0, bstap_pkg::IR_CAPTURE}, cap);
	endtask
	task automatic dr(input int n, input logic [31:0] din);
		bstap_tester_inst.scan(1'b0, n, din, got);
	endtask
	task automatic t_idcode;
		dr(32, 32'h0);
		chk_word("id after reset", ID, got);
		ir(bstap_pkg::OP_IDCODE);
		dr(32, 32'h0);
		chk_word("id opcode", ID, got);
		ir(bstap_pkg::OP_BYPASS);
		bstap_tester_inst.to_idle();
		dr(32, 32'h0);
		chk_word("id after tms reset", ID, got);
	endtask
	task automatic t_bypass;
		logic [4:0] ops [4] = '{bstap_pkg::OP_BYPASS, 5'h1E, 5'h06,
			bstap_pkg::OP_HIZ};
		@(posedge ref_clk);
		core_oe <= 4'hF;
		@(posedge ref_clk);
		chk_word("core enables", 32'hD, {28'h0, pad_oe});
		foreach (ops[i]) begin
			ir(ops[i]);
			dr(8, 32'h0000_00A5);
			chk_word("bypass", 32'h0000_004A, got);
		end
		chk_word("hiz enables", 32'h0, {28'h0, pad_oe});
	endtask
	// start opcode steps the user side on each idle rise
	task automatic t_start;
		logic q;
		int   n;
		ir(bstap_pkg::OP_START);
		n = step_count;
		repeat (3) bstap_tester_inst.clk_bit(1'b0, 1'b0, q);
		chk_word("idle steps", 32'h3, step_count - n);
	endtask
	task automatic t_sample;
		@(posedge ref_clk);
		pad_in <= 4'hA;
		core_out <= 4'h5;
		core_oe <= 4'h3;
		ir(bstap_pkg::OP_SAMPLE);
		dr(BL, 32'h0);
		chk_word("sample", cells(4'hA, 4'h5, 4'h3), got);
	endtask
	task automatic t_extest;
		ir(bstap_pkg::OP_SAMPLE);
		dr(BL, cells(4'h9, 4'hD, 4'h7));
		ir(bstap_pkg::OP_EXTEST);
		chk_word("extest out", 32'hD, {28'h0, pad_out});
		chk_word("extest oe", 32'h5, {28'h0, pad_oe});
		ir(bstap_pkg::OP_INTEST);
		chk_word("intest core", 32'h9, {28'h0, core_in});
	endtask
	task automatic t_usercode(input logic [31:0] exp);
		ir(bstap_pkg::OP_USER_CODE);
		dr(32, 32'h0);
		chk_word("user code", exp, got);
	endtask
	task automatic t_user;
		logic q;
		@(posedge ref_clk);
		one_tdo <= 1'b1;
		ir(bstap_pkg::OP_USER_ONE);
		chk_flag("select one", 1'b1, user_ctl.sel_one);
		dr(4, 32'h0);
		chk_word("user one", 32'hF, got);
		@(posedge ref_clk);
		one_tdo <= 1'b0;
		two_tdo <= 1'b1;
		ir(bstap_pkg::OP_USER_TWO);
		chk_flag("select two", 1'b1, user_ctl.sel_two);
		dr(4, 32'h0);
		chk_word("user two", 32'hF, got);
		// walk the data column, then back through reset
		bstap_tester_inst.clk_bit(1'b1, 1'b0, q);
		bstap_tester_inst.clk_bit(1'b0, 1'b0, q);
		chk_flag("capture state", 1'b1, user_ctl.capture);
		repeat (2) bstap_tester_inst.clk_bit(1'b0, 1'b0, q);
		chk_flag("shift state", 1'b1, user_ctl.shift);
		chk_flag("shift enable", 1'b1, tdo_oe);
		repeat (2) bstap_tester_inst.clk_bit(1'b1, 1'b0, q);
		chk_flag("update state", 1'b1, user_ctl.update);
		chk_flag("update enable", 1'b0, tdo_oe);
		repeat (3) bstap_tester_inst.clk_bit(1'b1, 1'b0, q);
		chk_flag("reset state", 1'b1, user_ctl.reset);
		bstap_tester_inst.clk_bit(1'b0, 1'b0, q);
		chk_flag("idle state", 1'b0, user_ctl.reset);
	endtask
	task automatic t_cfg_read;
		@(posedge ref_clk);
		rd_data <= 32'hC3A5_0F96;
		rd_valid <= 1'b1;
		ir(bstap_pkg::OP_CFG_READ);
		dr(32, 32'h0);
		chk_word("readback", 32'hC3A5_0F96, got);
		chk_word("readback takes", 32'h1, rd_pulses);
		@(posedge ref_clk);
		rd_valid <= 1'b0;
	endtask
	task automatic pop_word(input logic [31:0] exp);
		chk_word("load word", exp, wr_data);
		chk_flag("load valid", 1'b1, wr_valid);
		@(posedge ref_clk);
		wr_ready <= 1'b1;
		@(posedge ref_clk);
		wr_ready <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	// third word refused while the consumer stalls
	task automatic t_cfg_load;
		ir(bstap_pkg::OP_CFG_LOAD);
		dr(32, 32'h1111_2222);
		dr(32, 32'h3333_4444);
		dr(32, 32'h5555_6666);
		chk_flag("stall", 1'b1, wr_stall);
		pop_word(32'h1111_2222);
		pop_word(32'h3333_4444);
		chk_flag("drained", 1'b0, wr_valid);
	endtask
	// run limit against a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			final_report();
		end
	end
	// main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		bstap_tester_inst.to_idle();
		t_idcode();
		t_bypass();
		t_sample();
		t_extest();
		t_usercode(bstap_pkg::USER_CODE_NONE);
		t_cfg_read();
		t_cfg_load();
		// configuration changes only between scans
		@(posedge ref_clk);
		configured <= 1'b1;
		user_code <= 32'h1234_5678;
		t_usercode(32'h1234_5678);
		t_sample();
		t_extest();
		t_start();
		t_user();
		final_report();
	end
endmodule
